/* ams_pkg.sv */
// Constants and state types for the converter mux/mode sequencer.
// Assumes one 200 MHz clock and a 32-bit AXI4-Lite register master.
package ams_pkg;

  // ------------------------------------------------------------
  // Pin vector layout (synchronised inputs)
  // ------------------------------------------------------------
  localparam int P_WR = 0;
  localparam int P_RD = 1;
  localparam int P_CONV = 2;
  localparam int P_CS = 3;
  localparam int P_M0 = 4;
  localparam int P_M1 = 5;
  localparam int P_GAIN = 6;
  localparam int P_POL = 7;
  localparam int P_A0 = 8;
  localparam int P_DIFFERENTIAL_SELECT = 11;
  localparam int PIN_W = 12;
  // Strobes, start and select idle high
  localparam logic [PIN_W-1:0] PIN_RST = 12'h00F;

  // ------------------------------------------------------------
  // Entry word: differential_select, addr[2:0], polarity, gain, end flag
  // ------------------------------------------------------------
  localparam int W_DIFFERENTIAL_SELECT = 6;
  localparam int W_EOS = 0;
  localparam int SEQ_DEPTH = 16;

  // ------------------------------------------------------------
  // Timing and registers
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int CONV_TIME_NS = 550;
  localparam logic [7:0] CONV_CYC =
    8'((CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Gray order along direct, scan, run, program; equals {upper,lower}
  typedef enum logic [1:0] {
    MODE_DIRECT = 2'h0,
    MODE_SCAN = 2'h1,
    MODE_RUN = 2'h3,
    MODE_PROG = 2'h2
  } ams_mode_e;

endpackage : ams_pkg

/* ams_sequencer.sv */
// Mux address / mode sequencer of an eight-channel converter, with a
// 16 x 7 sequence memory and an AXI4-Lite status/control port.
// Assumes all mode, strobe and config pins are asynchronous to clk_i.
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - Both mode pins low: direct addressing
// - Latch strobe low passes, rising edge holds
// - Direct mode also captures on start fall
// - Scan mode ignores address, keeps config inputs
// - Scan single-ended 0..7 or four pairs
// - Scan counter steps one or two
// - Lower mode change clears scan counter
// - Start fall converts; report converted address
// - Sixteen entries, six bits plus end flag
// - Program mode: busy low, conversions refused
// - Any mode pin change clears pointer
// - Latch strobe rise stores entry, advances
// - Last written entry marks sequence end
// - Pointer wraps after sixteen writes
// - Read strobe low drives entry, rise advances
// - Word on address and top data outputs
// - End bit only on final entry; wraps
// - Lower pin high releases busy again
// - Run mode starts at entry zero, steps
// - After final entry pointer returns zero
// - Memory kept; latch strobe ignored in run
// - Start only with select low; no restart
module ams_sequencer
  import ams_pkg::*;
#(
  parameter int AXI_AW = 8
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic mode_sel_upper_i,
  input wire logic mode_sel_lower_i,
  input wire logic conv_start_n_i,
  input wire logic chip_sel_n_i,
  input wire logic wr_n_i,
  input wire logic rd_n_i,
  input wire logic differential_select_i,
  input wire logic gain_range_select_i,
  input wire logic polarity_select_i,
  input wire logic [2:0] mux_addr_in_i,
  output logic busy_o,
  output logic differential_select_flag_out_o,
  output logic [2:0] mux_addr_out_o,
  output logic addr_out_oe_o,
  output logic [2:0] data_msb_o,
  output logic data_msb_oe_o,
  output logic mux_differential_select_o,
  output logic [2:0] mux_chan_o,
  output logic mux_polarity_o,
  output logic mux_gain_o,
  output logic conv_active_o,
  input wire logic [AXI_AW-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [AXI_AW-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i
);

  typedef struct packed {
    logic [PIN_W-1:0] s1;
    logic [PIN_W-1:0] s2;
    logic [PIN_W-1:0] prev;
    logic [5:0] cfg;
    logic [SEQ_DEPTH-1:0][6:0] mem;
    logic [3:0] ptr;
    logic [2:0] scan;
    logic conv;
    logic [7:0] cnt;
    logic [5:0] cur;
    logic cur_eos;
    logic [5:0] mux;
    logic [3:0] res_addr;
    logic [3:0] aout;
    logic aoe;
    logic [2:0] msb;
    logic msb_oe;
    logic busy;
    logic [7:0] conv_len;
    logic awready;
    logic wready;
    logic aw_got;
    logic w_got;
    logic [AXI_AW-1:0] awaddr;
    logic [7:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } ams_state_s;

  ams_state_s q;
  ams_state_s n;

  logic [PIN_W-1:0] pins;
  ams_mode_e mode;
  logic wr_rise;
  logic rd_rise;
  logic conv_fall;
  logic m0_chg;
  logic mode_chg;
  logic start;
  logic [5:0] cfg_in;
  logic [5:0] eff_cfg;
  logic [5:0] use_cfg;
  logic use_eos;
  logic [6:0] rb_word;
  logic rd_back;

  assign pins = {differential_select_i, mux_addr_in_i, polarity_select_i,
                 gain_range_select_i, mode_sel_upper_i, mode_sel_lower_i,
                 chip_sel_n_i, conv_start_n_i, rd_n_i, wr_n_i};

  // ------------------------------------------------------------
  // Pin edges, seen only after the two-stage synchroniser
  // ------------------------------------------------------------
  // Edge detect after sync
  assign mode = ams_mode_e'(q.s2[P_M1:P_M0]);
  assign wr_rise = q.s2[P_WR] & ~q.prev[P_WR];
  assign rd_rise = q.s2[P_RD] & ~q.prev[P_RD];
  assign conv_fall = ~q.s2[P_CONV] & q.prev[P_CONV];
  assign m0_chg = q.s2[P_M0] ^ q.prev[P_M0];
  assign mode_chg = m0_chg | (q.s2[P_M1] ^ q.prev[P_M1]);
  assign cfg_in = {q.s2[P_DIFFERENTIAL_SELECT], q.s2[P_A0+:3], q.s2[P_POL], q.s2[P_GAIN]};
  assign rb_word = q.mem[q.ptr];
  assign rd_back = (mode == MODE_PROG) & ~q.s2[P_RD] & q.s2[P_WR];

  assign eff_cfg = (~q.s2[P_WR] | conv_fall) ? cfg_in : q.cfg;
  assign start = conv_fall & ~q.s2[P_CS] & ~q.conv & (mode != MODE_PROG);

  // ------------------------------------------------------------
  // Channel and configuration for the next conversion
  // ------------------------------------------------------------
  always_comb begin
    use_eos = 1'b0;
    unique case (mode)
      MODE_DIRECT: use_cfg = eff_cfg;
      MODE_SCAN: use_cfg = {eff_cfg[5], q.scan, eff_cfg[1:0]};
      MODE_RUN: begin
        use_cfg = rb_word[W_DIFFERENTIAL_SELECT:1];
        use_eos = rb_word[W_EOS];
      end
      MODE_PROG: use_cfg = eff_cfg;
    endcase
  end

  always_comb begin
    n = q;
    n.s1 = pins;
    n.s2 = q.s1;
    n.prev = q.s2;
    if (mode != MODE_RUN && (~q.s2[P_WR] | conv_fall)) begin
      n.cfg = cfg_in;
    end
    n.mux = q.conv ? q.cur : use_cfg;
    if (start) begin
      n.conv = 1'b1;
      n.cnt = (q.conv_len == 8'h00) ? 8'h01 : q.conv_len;
      n.cur = use_cfg;
      n.cur_eos = use_eos;
      n.mux = use_cfg;
    end else if (q.conv) begin
      n.cnt = q.cnt - 8'h01;
      if (q.cnt == 8'h01) begin
        n.conv = 1'b0;
        n.res_addr = q.cur[5:2];
        if (mode == MODE_SCAN) begin
          n.scan = q.scan + (q.cur[5] ? 3'h2 : 3'h1);
        end
        if (mode == MODE_RUN) begin
          n.ptr = q.cur_eos ? 4'h0 : q.ptr + 4'h1;
        end
      end
    end
    if (mode == MODE_PROG) begin
      if (wr_rise && q.s2[P_RD]) begin
        // Stale end flags of an older, longer sequence must not survive
        for (int i = 0; i < SEQ_DEPTH; i++) begin
          n.mem[i][W_EOS] = 1'b0;
        end
        n.mem[q.ptr] = {q.cfg, 1'b1};
        n.ptr = q.ptr + 4'h1;
      end
      if (rd_rise && q.s2[P_WR]) begin
        n.ptr = q.ptr + 4'h1;
      end
    end
    if (m0_chg) begin
      n.scan = 3'h0;
    end
    if (mode_chg) begin
      n.ptr = 4'h0;
    end
    n.aout = rd_back ? rb_word[6:3] : n.res_addr;
    n.msb = rb_word[2:0];
    n.msb_oe = rd_back;
    n.aoe = rd_back | ((mode != MODE_PROG) & ~q.s2[P_RD] & ~q.s2[P_CS]);
    n.busy = ~n.conv & (mode != MODE_PROG);

    // ----------------------------------------------------------
    // AXI4-Lite slave: one write and one read in flight
    // ----------------------------------------------------------
    if (s_axi_awvalid_i && q.awready) begin
      n.awaddr = s_axi_awaddr_i;
      n.aw_got = 1'b1;
      n.awready = 1'b0;
    end
    if (s_axi_wvalid_i && q.wready) begin
      n.wdata = s_axi_wdata_i[7:0];
      n.wstrb0 = s_axi_wstrb_i[0];
      n.w_got = 1'b1;
      n.wready = 1'b0;
    end
    if (q.aw_got && q.w_got && !q.bvalid) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = RESP_SLVERR;
      if (q.awaddr[7:2] == OFS_CTRL[7:2]) begin
        n.bresp = RESP_OKAY;
        if (q.wstrb0) begin
          n.conv_len = q.wdata;
        end
      end else if (q.awaddr[7:2] == OFS_STAT[7:2]) begin
        n.bresp = RESP_OKAY;
      end
    end
    if (q.bvalid && s_axi_bready_i) begin
      n.bvalid = 1'b0;
      n.awready = 1'b1;
      n.wready = 1'b1;
    end
    if (s_axi_arvalid_i && q.arready) begin
      n.arready = 1'b0;
      n.rvalid = 1'b1;
      n.rresp = RESP_OKAY;
      n.rdata = 32'h0;
      if (s_axi_araddr_i[7:2] == OFS_CTRL[7:2]) begin
        n.rdata = {24'h0, q.conv_len};
      end else if (s_axi_araddr_i[7:2] == OFS_STAT[7:2]) begin
        n.rdata = {17'h0, q.busy, q.conv, mode, q.ptr, q.scan, q.res_addr};
      end else begin
        n.rresp = RESP_SLVERR;
      end
    end
    if (q.rvalid && s_axi_rready_i) begin
      n.rvalid = 1'b0;
      n.arready = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      q <= '0;
      q.s1 <= PIN_RST;
      q.s2 <= PIN_RST;
      q.prev <= PIN_RST;
      q.busy <= 1'b1;
      q.conv_len <= CONV_CYC;
      q.awready <= 1'b1;
      q.wready <= 1'b1;
      q.arready <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign busy_o = q.busy;
  assign differential_select_flag_out_o = q.aout[3];
  assign mux_addr_out_o = q.aout[2:0];
  assign addr_out_oe_o = q.aoe;
  assign data_msb_o = q.msb;
  assign data_msb_oe_o = q.msb_oe;
  assign mux_differential_select_o = q.mux[5];
  assign mux_chan_o = q.mux[4:2];
  assign mux_polarity_o = q.mux[1];
  assign mux_gain_o = q.mux[0];
  assign conv_active_o = q.conv;
  assign s_axi_awready_o = q.awready;
  assign s_axi_wready_o = q.wready;
  assign s_axi_bresp_o = q.bresp;
  assign s_axi_bvalid_o = q.bvalid;
  assign s_axi_arready_o = q.arready;
  assign s_axi_rdata_o = q.rdata;
  assign s_axi_rresp_o = q.rresp;
  assign s_axi_rvalid_o = q.rvalid;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  a_prog_busy_low: assert property (
    (mode == MODE_PROG) |=> !busy_o)
    else $error("busy high in program mode");
  a_conv_busy_low: assert property (
    q.conv |-> !busy_o)
    else $error("busy high during conversion");
  a_deselect_refuse: assert property (
    (conv_fall && q.s2[P_CS] && !q.conv) |=> !q.conv)
    else $error("conversion started while deselected");
  a_scan_clear: assert property (
    m0_chg |=> (q.scan == 3'h0))
    else $error("scan counter not cleared");
  a_ptr_clear: assert property (
    mode_chg |=> (q.ptr == 4'h0))
    else $error("pointer not cleared on mode change");
  a_prog_store: assert property (
    (mode == MODE_PROG && wr_rise && q.s2[P_RD] && !mode_chg)
    |=> (q.mem[$past(q.ptr)] == {$past(q.cfg), 1'b1})
        && (q.ptr == 4'($past(q.ptr) + 4'h1)))
    else $error("entry not stored or pointer not advanced");
  a_scan_step: assert property (
    (mode == MODE_SCAN && q.conv && q.cnt == 8'h01 && !m0_chg && !start)
    |=> (q.scan == 3'($past(q.scan) + ($past(q.cur[5]) ? 3'h2 : 3'h1))))
    else $error("scan counter stepped wrongly");
  a_run_wrap: assert property (
    (mode == MODE_RUN && q.conv && q.cnt == 8'h01 && q.cur_eos && !mode_chg)
    |=> (q.ptr == 4'h0))
    else $error("pointer not returned after final entry");
  a_readback_drive: assert property (
    rd_back |=> data_msb_oe_o && addr_out_oe_o
      && (data_msb_o == $past(rb_word[2:0]))
      && ({differential_select_flag_out_o, mux_addr_out_o} == $past(rb_word[6:3])))
    else $error("readback word not driven");
  a_conv_length: assert property (
    (start && q.conv_len == 8'h03) |=> q.conv ##1 q.conv ##1 q.conv ##1 !q.conv)
    else $error("conversion length wrong");

  c_scan_conv: cover property (mode == MODE_SCAN && start);
  c_prog_write: cover property (mode == MODE_PROG && wr_rise && q.s2[P_RD]);
  c_readback: cover property (rd_back ##[1:20] rd_rise);
  c_run_wrap: cover property (mode == MODE_RUN && q.conv && q.cur_eos);

endmodule : ams_sequencer

`default_nettype wire

/* ams_host_model.sv */
// Host model: drives the mode, strobe, start and config pins.
// Assumes tasks are called from one bench process, after a clk_i edge.
`timescale 1ns/100ps
`default_nettype none
module ams_host_model (
  input wire logic clk_i,
  output logic mode_sel_upper_o,
  output logic mode_sel_lower_o,
  output logic conv_start_n_o,
  output logic chip_sel_n_o,
  output logic wr_n_o,
  output logic rd_n_o,
  output logic differential_select_o,
  output logic gain_range_select_o,
  output logic polarity_select_o,
  output logic [2:0] mux_addr_in_o
);
  initial begin
    {mode_sel_upper_o, mode_sel_lower_o} = 2'h0;
    {conv_start_n_o, wr_n_o, rd_n_o} = 3'h7;
    chip_sel_n_o = 1'b0;
    {differential_select_o, gain_range_select_o} = 2'h0;
    polarity_select_o = 1'b0;
    mux_addr_in_o = 3'h0;
  end

  // Pins are synchronised; four edges let each change settle inside
  task automatic hold_cycles(input int n);
    repeat (n) @(posedge clk_i);
  endtask : hold_cycles

  task automatic set_mode(input logic up, input logic lo);
    mode_sel_upper_o <= up;
    mode_sel_lower_o <= lo;
    hold_cycles(4);
  endtask : set_mode

  task automatic set_cfg(input logic d, input logic [2:0] a,
                         input logic p, input logic g);
    differential_select_o <= d;
    mux_addr_in_o <= a;
    polarity_select_o <= p;
    gain_range_select_o <= g;
    hold_cycles(4);
  endtask : set_cfg

  task automatic select(input logic n);
    chip_sel_n_o <= n;
    hold_cycles(4);
  endtask : select

  task automatic start_conv();
    conv_start_n_o <= 1'b0;
    hold_cycles(4);
    conv_start_n_o <= 1'b1;
    hold_cycles(4);
  endtask : start_conv

  task automatic write_entry(input logic d, input logic [2:0] a,
                             input logic p, input logic g);
    rd_n_o <= 1'b1;
    set_cfg(d, a, p, g);
    wr_n_o <= 1'b0;
    hold_cycles(4);
    wr_n_o <= 1'b1;
    hold_cycles(4);
  endtask : write_entry

  task automatic read_low();
    wr_n_o <= 1'b1;
    rd_n_o <= 1'b0;
    hold_cycles(4);
  endtask : read_low

  task automatic read_high();
    rd_n_o <= 1'b1;
    hold_cycles(4);
  endtask : read_high
endmodule : ams_host_model
`default_nettype wire

/* tb.sv */
// Bench for the mux/mode sequencer: host pin model plus AXI4-Lite master.
// Assumes a 200 MHz clock and conversion length set to 3 over the bus.
`timescale 1ns/100ps
`default_nettype none
module tb
  import ams_pkg::*;
;
  logic clk_i, resetn_i, m_up, m_lo, cst_n, cs_n, wr_n, rd_n;
  logic dsel, gsel, psel, busy_o, differential_select_flag_out_o, addr_out_oe_o;
  logic data_msb_oe_o, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [2:0] ain, mux_addr_out_o, data_msb_o, mux_chan_o;
  logic mux_differential_select_o, mux_polarity_o, mux_gain_o, conv_active_o;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp, r;
  int mismatches, cmp_count, cyc;

  ams_host_model u_ams_host_model (.clk_i(clk_i), .mode_sel_upper_o(m_up),
    .mode_sel_lower_o(m_lo), .conv_start_n_o(cst_n), .chip_sel_n_o(cs_n),
    .wr_n_o(wr_n), .rd_n_o(rd_n), .differential_select_o(dsel),
    .gain_range_select_o(gsel), .polarity_select_o(psel),
    .mux_addr_in_o(ain));

  ams_sequencer u_ams_sequencer (.clk_i(clk_i), .resetn_i(resetn_i),
    .mode_sel_upper_i(m_up), .mode_sel_lower_i(m_lo),
    .conv_start_n_i(cst_n), .chip_sel_n_i(cs_n), .wr_n_i(wr_n),
    .rd_n_i(rd_n), .differential_select_i(dsel),
    .gain_range_select_i(gsel), .polarity_select_i(psel),
    .mux_addr_in_i(ain), .busy_o(busy_o),
    .differential_select_flag_out_o(differential_select_flag_out_o), .mux_addr_out_o(mux_addr_out_o),
    .addr_out_oe_o(addr_out_oe_o), .data_msb_o(data_msb_o),
    .data_msb_oe_o(data_msb_oe_o), .mux_differential_select_o(mux_differential_select_o),
    .mux_chan_o(mux_chan_o), .mux_polarity_o(mux_polarity_o),
    .mux_gain_o(mux_gain_o), .conv_active_o(conv_active_o),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic print_verdict();
    $display("comparisons=%0d mismatches=%0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : print_verdict

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      print_verdict();
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite master: bready/rready held high from the request on
  // ----------------------------------------------------------------
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    awaddr <= a;
    wdata <= v;
    {awvalid, wvalid, bready} <= 3'h7;
    do begin
      @(posedge clk_i);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a);
    @(posedge clk_i);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do begin
      @(posedge clk_i);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    {d, r} = {rdata, rresp};
    rready <= 1'b0;
  endtask : axi_rd

  task automatic conv_check(input logic [3:0] exp);
    int n;
    n = 0;
    u_ams_host_model.start_conv();
    while (busy_o !== 1'b1 && n < 100) begin
      @(posedge clk_i);
      n++;
    end
    chk({28'h0, differential_select_flag_out_o, mux_addr_out_o}, {28'h0, exp});
  endtask : conv_check

  task automatic read_check(input logic [6:0] exp);
    u_ams_host_model.read_low();
    chk({addr_out_oe_o, data_msb_oe_o, differential_select_flag_out_o, mux_addr_out_o,
      data_msb_o}, {2'h3, exp});
    u_ams_host_model.read_high();
    chk(data_msb_oe_o, 1'b0);
  endtask : read_check

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_regs();
    axi_rd(OFS_CTRL);
    chk(d, {24'h0, CONV_CYC});
    axi_wr(OFS_CTRL, 32'h3);
    chk(r, RESP_OKAY);
    axi_wr(OFS_STAT, 32'hFF);
    chk(r, RESP_OKAY);
    axi_wr(8'h10, 32'h7);
    chk(r, RESP_SLVERR);
    axi_rd(OFS_CTRL);
    chk(d, 32'h3);
    axi_rd(8'h10);
    chk(r, RESP_SLVERR);
    axi_rd(OFS_STAT);
    chk(d, 32'h4000);
  endtask : test_regs

  task automatic test_direct();
    u_ams_host_model.set_mode(1'b0, 1'b0);
    u_ams_host_model.set_cfg(1'b0, 3'h5, 1'b0, 1'b0);
    conv_check(4'h5);
    u_ams_host_model.set_cfg(1'b1, 3'h6, 1'b1, 1'b1);
    conv_check(4'hE);
    chk({conv_active_o, mux_differential_select_o, mux_chan_o, mux_polarity_o, mux_gain_o},
      {1'b0, 6'h3B});
    u_ams_host_model.select(1'b1);
    u_ams_host_model.set_cfg(1'b0, 3'h3, 1'b0, 1'b0);
    conv_check(4'hE);
    u_ams_host_model.select(1'b0);
    u_ams_host_model.write_entry(1'b0, 3'h1, 1'b1, 1'b0);
    u_ams_host_model.set_cfg(1'b1, 3'h6, 1'b1, 1'b1);
    chk({mux_differential_select_o, mux_chan_o, mux_polarity_o, mux_gain_o},
      6'h06);
  endtask : test_direct

  task automatic test_scan();
    u_ams_host_model.set_mode(1'b0, 1'b1);
    u_ams_host_model.set_cfg(1'b0, 3'h7, 1'b0, 1'b0);
    conv_check(4'h0);
    conv_check(4'h1);
    u_ams_host_model.set_cfg(1'b1, 3'h7, 1'b0, 1'b0);
    conv_check(4'hA);
    u_ams_host_model.set_cfg(1'b0, 3'h7, 1'b0, 1'b0);
    conv_check(4'h4);
    u_ams_host_model.set_mode(1'b0, 1'b0);
    u_ams_host_model.set_mode(1'b0, 1'b1);
    conv_check(4'h0);
  endtask : test_scan

  task automatic test_prog();
    u_ams_host_model.set_mode(1'b1, 1'b0);
    chk(busy_o, 1'b0);
    conv_check(4'h0);
    u_ams_host_model.write_entry(1'b0, 3'h5, 1'b1, 1'b0);
    u_ams_host_model.write_entry(1'b1, 3'h2, 1'b0, 1'b1);
    u_ams_host_model.write_entry(1'b0, 3'h7, 1'b1, 1'b1);
    u_ams_host_model.set_mode(1'b1, 1'b1);
    u_ams_host_model.set_mode(1'b1, 1'b0);
    read_check(7'h2C);
    read_check(7'h52);
    read_check(7'h3F);
    u_ams_host_model.set_mode(1'b1, 1'b1);
    chk(busy_o, 1'b1);
  endtask : test_prog

  task automatic test_run();
    conv_check(4'h5);
    conv_check(4'hA);
    conv_check(4'h7);
    conv_check(4'h5);
    u_ams_host_model.set_mode(1'b0, 1'b0);
    u_ams_host_model.set_mode(1'b1, 1'b1);
    conv_check(4'h5);
  endtask : test_run

  initial begin
    {mismatches, cmp_count} = '0;
    resetn_i = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {awaddr, araddr, wdata} = '0;
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    test_regs();
    test_direct();
    test_scan();
    test_prog();
    test_run();
    print_verdict();
  end
endmodule : tb
`default_nettype wire
